// file: design/acs_top.sv
// top: axi4-lite register slave around the sar sequencer
// assumes synchronous srst_in and a comparator on cmp_in
`timescale 1ns/1ns
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        cmp_in,
    input  wire logic [6:0]  pin_digital_in,
    output logic [9:0]       dac_out,
    output logic             sample_out,
    output logic [2:0]       channel_out,
    output logic [1:0]       reference_select_out,
    output logic             converter_on_out,
    output logic [6:0]       analog_pin_out,
    output logic [6:0]       pin_digital_out,
    output logic             conversion_done_flag_out
);
    acs_ctrl_t ctrl, next_ctrl;
    logic [7:0] pincfg, next_pincfg;
    logic [7:0] timing, next_timing;
    logic [9:0] result, next_result;
    logic flag, next_flag;
    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [6:0] pin_dig, next_pin_dig;
    logic [6:0] apin, next_apin;
    logic do_write, start_req;
    logic busy, sample_w, done;
    logic [9:0] dac_w, core_result;
    acs_cmd_t cmd;

    // register read decode, shared by read path
    function automatic logic [31:0] read_word(input logic [7:0] a, input acs_ctrl_t c,
                                              input logic [7:0] p, input logic [7:0] t,
                                              input logic [9:0] r, input logic f);
        unique case (a)
            ACS_OFF_CTRL0:  read_word = {24'h0, c.ref_sel, 1'b0, c.channel, c.go, c.on};
            ACS_OFF_PINCFG: read_word = {24'h0, p};
            ACS_OFF_TIMING: read_word = {24'h0, t};
            ACS_OFF_RES_HI: read_word = {30'h0, r[9:8]};
            ACS_OFF_RES_LO: read_word = {24'h0, r[7:0]};
            ACS_OFF_STATUS: read_word = {31'h0, f};
            default:        read_word = 32'h0;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ACS_OFF_CTRL0) || (a == ACS_OFF_PINCFG) || (a == ACS_OFF_TIMING) ||
                  (a == ACS_OFF_RES_HI) || (a == ACS_OFF_RES_LO) || (a == ACS_OFF_STATUS);
    endfunction

    assign do_write = aw_got && w_got && !bvalid;
    // start only taken with the converter on and idle
    assign start_req = do_write && (aw_addr == ACS_OFF_CTRL0) && w_strb[0] &&
                       w_data[ACS_GO_BIT] && w_data[ACS_ON_BIT] && !busy;
    assign cmd.start   = start_req;
    assign cmd.acq_sel = timing[5:3];

    acs_sar_core u_core (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .cmd_in        (cmd),
        .abort_in      (!ctrl.on && !start_req),
        .no_channel_in (ctrl.channel == ACS_CH_NONE),
        .cmp_in        (cmp_in),
        .busy_out      (busy),
        .sample_out    (sample_w),
        .dac_out       (dac_w),
        .done_out      (done),
        .result_out    (core_result)
    );

    // bus handshake and register next values
    always_comb begin
        next_aw_got  = aw_got;
        next_aw_addr = aw_addr;
        next_w_got   = w_got;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_ctrl    = ctrl;
        next_pincfg  = pincfg;
        next_timing  = timing;
        next_result  = result;
        next_flag    = flag;
        if (s_axi_awvalid_in && !aw_got) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_axi_awaddr_in & 8'hfc;
        end
        if (s_axi_wvalid_in && !w_got) begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
        if (bvalid && s_axi_bready_in) next_bvalid = 1'b0;
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = addr_ok(aw_addr) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
            if (w_strb[0]) begin
                unique case (aw_addr)
                    ACS_OFF_CTRL0: begin
                        next_ctrl.on      = w_data[ACS_ON_BIT];
                        next_ctrl.channel = w_data[ACS_CH_LSB +: 3];
                        next_ctrl.ref_sel = w_data[ACS_REF_LSB +: 2];
                    end
                    ACS_OFF_PINCFG: next_pincfg = w_data[7:0] & ACS_PINCFG_WMASK;
                    ACS_OFF_TIMING: next_timing = w_data[7:0] & ACS_TIMING_WMASK;
                    ACS_OFF_STATUS: if (w_data[0]) next_flag = 1'b0;
                    default: ;
                endcase
            end
        end
        // go tracks a running conversion while on
        if (start_req) next_ctrl.go = 1'b1;
        if (!busy && !start_req) next_ctrl.go = 1'b0;
        if (!next_ctrl.on) next_ctrl.go = 1'b0;
        // completion: load result, set flag (set wins); go drops with busy
        if (done) begin
            next_result  = core_result;
            next_flag    = 1'b1;
        end
        if (rvalid && s_axi_rready_in) next_rvalid = 1'b0;
        if (s_axi_arvalid_in && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = addr_ok(s_axi_araddr_in & 8'hfc) ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
            next_rdata  = read_word(s_axi_araddr_in & 8'hfc, ctrl, pincfg, timing, result, flag);
        end
    end

    // analog pins gate the digital input to zero
    always_comb begin
        next_pin_dig = pin_digital_in & pincfg[6:0];
        next_apin    = ~pincfg[6:0];
    end

    // register stage
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ctrl    <= '0;
            pincfg  <= ACS_RESET_BYTE;
            timing  <= ACS_RESET_BYTE;
            result  <= '0;
            flag    <= 1'b0;
            aw_got  <= 1'b0;
            aw_addr <= 8'h00;
            w_got   <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= ACS_RESP_OKAY;
            rvalid  <= 1'b0;
            rresp   <= ACS_RESP_OKAY;
            rdata   <= 32'h0;
            pin_dig <= 7'h00;
            apin    <= 7'h7f;
        end else begin
            ctrl    <= next_ctrl;
            pincfg  <= next_pincfg;
            timing  <= next_timing;
            result  <= next_result;
            flag    <= next_flag;
            aw_got  <= next_aw_got;
            aw_addr <= next_aw_addr;
            w_got   <= next_w_got;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            pin_dig <= next_pin_dig;
            apin    <= next_apin;
        end
    end

    // output stage, all registered
    logic [9:0] dac_q;
    logic       sample_q;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            dac_q    <= 10'h000;
            sample_q <= 1'b0;
        end else begin
            dac_q    <= dac_w;
            sample_q <= sample_w;
        end
    end

    assign s_axi_awready_out        = !aw_got;
    assign s_axi_wready_out         = !w_got;
    assign s_axi_bvalid_out         = bvalid;
    assign s_axi_bresp_out          = bresp;
    assign s_axi_arready_out        = !rvalid;
    assign s_axi_rvalid_out         = rvalid;
    assign s_axi_rresp_out          = rresp;
    assign s_axi_rdata_out          = rdata;
    assign dac_out                  = dac_q;
    assign sample_out               = sample_q;
    assign channel_out              = ctrl.channel;
    assign reference_select_out     = ctrl.ref_sel;
    assign converter_on_out         = ctrl.on;
    assign analog_pin_out           = apin;
    assign pin_digital_out          = pin_dig;
    assign conversion_done_flag_out = flag;

    sequence s_done_seen;
        done;
    endsequence
    a_done_loads: assert property (@(posedge mclk_in) disable iff (srst_in)
        s_done_seen |=> result == $past(core_result) && flag && ctrl.go == $past(start_req))
        else $error("completion did not load result and flag");
    a_full_scale: assert property (@(posedge mclk_in) disable iff (srst_in)
        done && ctrl.channel == ACS_CH_NONE |=> result == ACS_FULL_SCALE)
        else $error("unused channel did not give full scale");
    a_off_no_go: assert property (@(posedge mclk_in) disable iff (srst_in)
        !ctrl.on |-> !ctrl.go)
        else $error("go set while off");
    a_go_busy: assert property (@(posedge mclk_in) disable iff (srst_in)
        ctrl.on && busy |-> ##0 ctrl.go || $past(done))
        else $error("go not shown while busy");
    a_bit5_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
        rvalid && $past(s_axi_araddr_in[7:2]) == 6'h00 && $rose(rvalid) |-> !rdata[5])
        else $error("bit five read nonzero");
    a_analog_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
        ##1 (pin_dig & ~$past(pincfg[6:0])) == 7'h00)
        else $error("analog pin read nonzero");
    a_start_acq: assert property (@(posedge mclk_in) disable iff (srst_in)
        start_req && timing[5:3] != 3'h0 |=> busy ##1 sample_q)
        else $error("acquisition did not begin");
    a_off_abort: assert property (@(posedge mclk_in) disable iff (srst_in)
        ctrl.on ##1 !ctrl.on |=> !busy)
        else $error("conversion not aborted");

    // register writes land in the fields they address
    sequence s_ctrl0_write;
        do_write && w_strb[0] && aw_addr == ACS_OFF_CTRL0;
    endsequence
    a_ref_field: assert property (@(posedge mclk_in) disable iff (srst_in)
        s_ctrl0_write |=> ctrl.ref_sel == $past(w_data[ACS_REF_LSB +: 2]))
        else $error("reference field not written");
    a_channel_field: assert property (@(posedge mclk_in) disable iff (srst_in)
        s_ctrl0_write |=> ctrl.channel == $past(w_data[ACS_CH_LSB +: 3]))
        else $error("channel field not written");
    a_on_follows: assert property (@(posedge mclk_in) disable iff (srst_in)
        s_ctrl0_write |=> ctrl.on == $past(w_data[ACS_ON_BIT]))
        else $error("on bit not written");
    a_flag_clear: assert property (@(posedge mclk_in) disable iff (srst_in)
        do_write && w_strb[0] && aw_addr == ACS_OFF_STATUS && w_data[0] && !done |=> !flag)
        else $error("flag not cleared by write");
    a_pincfg_write: assert property (@(posedge mclk_in) disable iff (srst_in)
        do_write && w_strb[0] && aw_addr == ACS_OFF_PINCFG |=> pincfg == ($past(w_data[7:0]) & ACS_PINCFG_WMASK))
        else $error("pin config not written");
    a_strb_ignore: assert property (@(posedge mclk_in) disable iff (srst_in)
        do_write && !w_strb[0] |=> pincfg == $past(pincfg) && timing == $past(timing))
        else $error("write without lane zero changed a register");
    // reset leaves the converter off, idle and unflagged
    a_reset_off: assert property (@(posedge mclk_in)
        srst_in |=> !ctrl.on && !busy && !flag)
        else $error("reset did not switch converter off");
endmodule // acs_top
`default_nettype wire

// file: design/acs_pkg.sv
// constants, register map and field layout for the converter control block
// assumes a 32-bit axi4-lite slave, one clock at 20 MHz
package acs_pkg;
    // register byte offsets
    localparam logic [7:0] ACS_OFF_CTRL0   = 8'h00;
    localparam logic [7:0] ACS_OFF_PINCFG  = 8'h04;
    localparam logic [7:0] ACS_OFF_TIMING  = 8'h08;
    localparam logic [7:0] ACS_OFF_RES_HI  = 8'h0c;
    localparam logic [7:0] ACS_OFF_RES_LO  = 8'h10;
    localparam logic [7:0] ACS_OFF_STATUS  = 8'h14;
    // control register 0 fields
    localparam int ACS_ON_BIT    = 0;
    localparam int ACS_GO_BIT    = 1;
    localparam int ACS_CH_LSB    = 2;
    localparam int ACS_REF_LSB   = 6;
    localparam logic [7:0] ACS_CTRL0_WMASK = 8'hdd;
    localparam logic [7:0] ACS_PINCFG_WMASK = 8'h7f;
    localparam logic [7:0] ACS_TIMING_WMASK = 8'h38;
    localparam logic [7:0] ACS_RESET_BYTE  = 8'h00;
    // channel codes
    localparam logic [2:0] ACS_CH_NONE     = 3'h7;
    localparam logic [9:0] ACS_FULL_SCALE  = 10'h3ff;
    localparam int ACS_RES_BITS = 10;
    localparam int ACS_NUM_CH   = 7;
    // bit period: 100 ns at 20 MHz clock
    localparam int ACS_CLK_NS   = 50;
    localparam int ACS_TBIT_NS  = 100;
    localparam int ACS_TBIT_CYC = (ACS_TBIT_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    localparam logic [3:0] ACS_BITCNT_LAST = 4'h9;
    // axi responses
    localparam logic [1:0] ACS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [2:0] channel;
        logic       go;
        logic       on;
    } acs_ctrl_t;

    typedef struct packed {
        logic       start;
        logic [2:0] acq_sel;
    } acs_cmd_t;

    // acquisition length in bit periods for each select code
    function automatic logic [4:0] acs_acq_periods(input logic [2:0] sel);
        unique case (sel)
            3'h0: acs_acq_periods = 5'h00;
            3'h1: acs_acq_periods = 5'h02;
            3'h2: acs_acq_periods = 5'h04;
            3'h3: acs_acq_periods = 5'h06;
            3'h4: acs_acq_periods = 5'h08;
            3'h5: acs_acq_periods = 5'h0c;
            3'h6: acs_acq_periods = 5'h10;
            default: acs_acq_periods = 5'h14;
        endcase
    endfunction
endpackage

// file: design/acs_sar_core.sv
// successive approximation sequencer: acquisition then ten bit trials
// assumes comparator input is valid synchronous to mclk_in
`timescale 1ns/1ns
`default_nettype none
module acs_sar_core
    import acs_pkg::*;
(
    input  wire logic                    mclk_in,
    input  wire logic                    srst_in,
    input  wire acs_cmd_t                cmd_in,
    input  wire logic                    abort_in,
    input  wire logic                    no_channel_in,
    input  wire logic                    cmp_in,
    output logic                         busy_out,
    output logic                         sample_out,
    output logic [ACS_RES_BITS-1:0]      dac_out,
    output logic                         done_out,
    output logic [ACS_RES_BITS-1:0]      result_out
);
    typedef enum logic [1:0] {ACS_IDLE, ACS_ACQ, ACS_CONV} acs_state_t;
    acs_state_t state, next_state;
    logic [4:0] periods, next_periods;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] tick, next_tick;
    logic [ACS_RES_BITS-1:0] sar, next_sar;
    logic done, next_done;
    logic [ACS_RES_BITS-1:0] result, next_result;
    logic tick_en;

    // bit period enable divider
    assign tick_en = (tick == 8'(ACS_TBIT_CYC - 1));

    // sequencer next state
    always_comb begin
        next_state   = state;
        next_periods = periods;
        next_bitcnt  = bitcnt;
        next_tick    = tick_en ? 8'h00 : tick + 8'h01;
        next_sar     = sar;
        next_done    = 1'b0;
        next_result  = result;
        unique case (state)
            ACS_IDLE: begin
                next_tick = 8'h00;
                if (cmd_in.start) begin
                    next_periods = acs_acq_periods(cmd_in.acq_sel);
                    // zero acquisition converts at once
                    next_state = (next_periods == 5'h00) ? ACS_CONV : ACS_ACQ;
                    next_bitcnt = 4'h0;
                    next_sar = {1'b1, {(ACS_RES_BITS-1){1'b0}}};
                end
            end
            ACS_ACQ: begin
                if (tick_en) begin
                    next_periods = periods - 5'h01;
                    if (periods == 5'h01) next_state = ACS_CONV;
                end
            end
            ACS_CONV: begin
                if (tick_en) begin
                    // keep or drop the trial bit, then try the next one
                    for (int i = 0; i < ACS_RES_BITS; i++) begin
                        if (i == ACS_RES_BITS - 1 - int'(bitcnt)) begin
                            next_sar[i] = cmp_in;
                            if (i > 0) next_sar[i-1] = 1'b1;
                        end
                    end
                    next_bitcnt = bitcnt + 4'h1;
                    if (bitcnt == ACS_BITCNT_LAST) begin
                        next_state  = ACS_IDLE;
                        next_done   = 1'b1;
                        next_result = no_channel_in ? ACS_FULL_SCALE : next_sar;
                    end
                end
            end
            default: next_state = ACS_IDLE;
        endcase
        if (abort_in) begin
            next_state = ACS_IDLE;
            next_done  = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state   <= ACS_IDLE;
            periods <= 5'h00;
            bitcnt  <= 4'h0;
            tick    <= 8'h00;
            sar     <= '0;
            done    <= 1'b0;
            result  <= '0;
        end else begin
            state   <= next_state;
            periods <= next_periods;
            bitcnt  <= next_bitcnt;
            tick    <= next_tick;
            sar     <= next_sar;
            done    <= next_done;
            result  <= next_result;
        end
    end

    assign busy_out   = (state != ACS_IDLE);
    assign sample_out = (state == ACS_ACQ);
    assign dac_out    = sar;
    assign done_out   = done;
    assign result_out = result;

    a_conv_length: assert property (@(posedge mclk_in) disable iff (srst_in)
        $rose(state == ACS_CONV) && !abort_in |-> (state == ACS_CONV) [*8] ##1 (state == ACS_CONV))
        else $error("conversion ended early");
    a_zero_acq: assert property (@(posedge mclk_in) disable iff (srst_in)
        state == ACS_IDLE && cmd_in.start && cmd_in.acq_sel == 3'h0 && !abort_in |=> state == ACS_CONV)
        else $error("zero acquisition did not convert at once");
endmodule // acs_sar_core
`default_nettype wire

// file: tb/adc_control_channel_select_bench.sv
// self-checking bench for the converter control block: registers, pins, conversions
// assumes acs_pkg compiled first; bench is the axi4-lite master and the comparator
`timescale 1ns/1ns
`default_nettype none
module adc_control_channel_select_bench import acs_pkg::*;;
    localparam int ACQ_TAD [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    logic        mclk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata   = 32'h0;
    logic        wvalid  = 1'b0;
    logic [3:0]  wstrb   = 4'hf;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready  = 1'b0;
    logic        cmp_in;
    logic [6:0]  pin_in  = 7'h00;
    logic [9:0]  dac_out;
    logic        sample_out;
    logic [2:0]  channel_out;
    logic [1:0]  ref_out;
    logic        on_out;
    logic [6:0]  analog_out;
    logic [6:0]  pin_out;
    logic        flag_out;
    logic [9:0]  vin     = 10'h000;
    int          samp_cnt = 0;
    int          bad_count = 0;
    int          compares = 0;

    // clock and ideal comparator model
    always #25 mclk_in = ~mclk_in;
    assign cmp_in = (vin >= dac_out);
    always @(posedge mclk_in) if (sample_out === 1'b1) samp_cnt++;

    acs_top uut (.mclk_in(mclk_in), .srst_in(srst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .cmp_in(cmp_in), .pin_digital_in(pin_in), .dac_out(dac_out), .sample_out(sample_out),
        .channel_out(channel_out), .reference_select_out(ref_out), .converter_on_out(on_out),
        .analog_pin_out(analog_out), .pin_digital_out(pin_out), .conversion_done_flag_out(flag_out));

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // axi write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge mclk_in);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge mclk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    // axi read: hold arvalid until taken, rready until rvalid
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge mclk_in);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge mclk_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk(r, ACS_RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(r, ACS_RESP_OKAY);
    endtask

    // one full acquisition plus conversion, result and flag checked
    task automatic convert(input logic [2:0] ch, input logic [1:0] rf, input logic [2:0] acq, input logic [9:0] v);
        logic [31:0] d;
        logic [9:0]  expv;
        int          n;
        expv = (ch == ACS_CH_NONE) ? ACS_FULL_SCALE : v;
        vin <= v;
        wr(ACS_OFF_TIMING, {26'h0, acq, 3'h0});
        samp_cnt = 0;
        wr(ACS_OFF_CTRL0, {24'h0, rf, 1'b0, ch, 2'b11});
        rd(ACS_OFF_CTRL0, d);
        chk(d[1], 1'b1);
        chk(channel_out, ch);
        chk(ref_out, rf);
        for (n = 0; n < 100; n++) begin
            rd(ACS_OFF_CTRL0, d);
            if (d[1] === 1'b0) break;
        end
        chk(d, {24'h0, rf, 1'b0, ch, 2'b01});
        chk(samp_cnt, 2 * ACQ_TAD[acq]);
        rd(ACS_OFF_RES_HI, d);
        chk(d, {30'h0, expv[9:8]});
        rd(ACS_OFF_RES_LO, d);
        chk(d, {24'h0, expv[7:0]});
        rd(ACS_OFF_STATUS, d);
        chk(d, 32'h1);
        wr(ACS_OFF_STATUS, 32'h1);
        rd(ACS_OFF_STATUS, d);
        chk(d, 32'h0);
        repeat (2 * ACS_TBIT_CYC) @(posedge mclk_in);
    endtask

    // watchdog
    initial begin
        repeat (40000) @(posedge mclk_in);
        bad_count++;
        print_verdict;
    end

    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [6:0]  cfg;
        logic [6:0]  pv;
        void'($urandom(32'h09cc5665));
        repeat (3) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk(analog_out, 7'h7f);
        chk(on_out, 1'b0);
        rd(ACS_OFF_CTRL0, d);
        chk(d, 32'h0);
        rd(ACS_OFF_PINCFG, d);
        chk(d, 32'h0);
        // reserved bit and on bit
        wr(ACS_OFF_CTRL0, 32'hfd);
        rd(ACS_OFF_CTRL0, d);
        chk(d, 32'hdd);
        chk(on_out, 1'b1);
        wr(ACS_OFF_CTRL0, 32'h20);
        rd(ACS_OFF_CTRL0, d);
        chk(d, 32'h0);
        chk(on_out, 1'b0);
        // start while switched off
        samp_cnt = 0;
        wr(ACS_OFF_CTRL0, 32'h02);
        repeat (30) @(posedge mclk_in);
        rd(ACS_OFF_CTRL0, d);
        chk(d, 32'h0);
        chk(samp_cnt, 0);
        chk(flag_out, 1'b0);
        // pin configuration with random patterns and both extremes
        for (int i = 0; i < 6; i++) begin
            cfg = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
            pv = 7'($urandom);
            pin_in <= pv;
            wr(ACS_OFF_PINCFG, {24'h0, 1'b1, cfg});
            rd(ACS_OFF_PINCFG, d);
            chk(d, {25'h0, cfg});
            repeat (3) @(posedge mclk_in);
            chk(analog_out, 7'(~cfg));
            chk(pin_out, pv & cfg);
        end
        // write with byte lane zero off leaves the register alone
        wstrb <= 4'h0;
        wr(ACS_OFF_PINCFG, 32'h0);
        wstrb <= 4'hf;
        rd(ACS_OFF_PINCFG, d);
        chk(d, {25'h0, cfg});
        // every channel code, reference code and acquisition code
        for (int c = 0; c < 8; c++)
            convert(3'(c), 2'(c), 3'(c), (c == 7) ? 10'h000 : (c == 1) ? 10'h3ff : (c == 0) ? 10'h000 : 10'($urandom));
        for (int i = 0; i < 4; i++)
            convert(3'($urandom % ACS_NUM_CH), 2'($urandom), 3'h0, 10'($urandom));
        // unmapped place
        axi_wr(8'h18, 32'hffffffff, r);
        chk(r, ACS_RESP_SLVERR);
        axi_rd(8'h18, d, r);
        chk(r, ACS_RESP_SLVERR);
        chk(d, 32'h0);
        // reset in the middle of a long acquisition
        wr(ACS_OFF_TIMING, 32'h38);
        wr(ACS_OFF_CTRL0, 32'h03);
        repeat (10) @(posedge mclk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
        chk(on_out, 1'b0);
        chk(sample_out, 1'b0);
        repeat (80) @(posedge mclk_in);
        chk(flag_out, 1'b0);
        rd(ACS_OFF_CTRL0, d);
        chk(d, 32'h0);
        rd(ACS_OFF_TIMING, d);
        chk(d, 32'h0);
        print_verdict;
    end
endmodule // adc_control_channel_select_bench
`default_nettype wire
